// *** sbc_std_bus_interface.sv ***
// Backplane interface of an 8-bit processor card: runs machine cycles on the
// backplane pins, floats them for DMA, makes refresh, sync and reset.
// Assumes backplane inputs are synchronous to clk; pins resolved outside.
`timescale 1ns/1ns
`include "sbc_params.svh"
module sbc_std_bus_interface import sbc_pkg::*; #(
	parameter int RESET_CYCLES = `SBC_RESET_CYCLES
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic reqValid,
	input wire sbc_kind_e reqKind,
	input wire logic [15:0] reqAddr,
	input wire logic [7:0] reqData,
	output logic reqReady,
	output logic respValid,
	output logic [7:0] respData,
	input wire logic onboardSel,
	input wire logic [7:0] onboardData,
	input wire logic refLoad,
	input wire logic [7:0] refValue,
	input wire logic useExtClk,
	input wire logic extClk_n,
	input wire logic pbReset_n,
	input wire logic [7:0] dataIn,
	output logic [7:0] dataOut,
	output logic dataOe_n,
	output logic [15:0] addrOut,
	output logic addrOe_n,
	output logic memReq_n,
	output logic ioReq_n,
	output logic rd_n,
	output logic wr_n,
	output logic refreshCycleFlag_n,
	output logic mcSync_n,
	output logic opcodeFetchCycleFlag_n,
	output logic intAck_n,
	output logic ctrlOe_n,
	output logic memExp_n,
	output logic ioExp_n,
	input wire logic busReq_n,
	output logic busAck_n,
	input wire logic waitRq_n,
	output logic sysReset_n,
	output logic clockOut_n,
	input wire logic priChainIn,
	output logic priChainOut
);
	sbc_time_if tm();

	sbc_timebase #(
		.RESET_CYCLES(RESET_CYCLES)
	) u_timebase (
		.clk(clk),
		.reset_n(reset_n),
		.pbReset_n(pbReset_n),
		.extClk_n(extClk_n),
		.useExtClk(useExtClk),
		.tm(tm)
	);

	sbc_state_e state;
	sbc_state_e next_state;
	sbc_kind_e kind;
	sbc_kind_e next_kind;
	logic [15:0] addr;
	logic [15:0] next_addr;
	logic [7:0] wdata;
	logic [7:0] next_wdata;
	logic onb;
	logic next_onb;
	logic pend;
	logic next_pend;
	logic [1:0] waitCnt;
	logic [1:0] next_waitCnt;
	logic [7:0] rdData;
	logic [7:0] next_rdData;
	logic [7:0] refCnt;
	logic [7:0] next_refCnt;
	logic next_respValid;
	logic next_reqReady;
	logic [1:0] autoW;
	logic [7:0] busData;
	logic accept;

	assign accept = reqValid && reqReady;
	assign busData = onb ? onboardData : dataIn;

	always_comb begin
		case (kind)
			SBC_IO_RD, SBC_IO_WR: autoW = `SBC_IO_WAITS;
			SBC_INT_ACK: autoW = `SBC_INTA_WAITS;
			default: autoW = `SBC_NO_WAITS;
		endcase
	end

	// Cycle engine; steps only on time-state boundaries
	always_comb begin
		next_state = state;
		next_kind = kind;
		next_addr = addr;
		next_wdata = wdata;
		next_onb = onb;
		next_pend = pend;
		next_waitCnt = waitCnt;
		next_rdData = rdData;
		next_refCnt = refCnt;
		next_respValid = 1'b0;
		if (accept) begin
			next_pend = 1'b1;
			next_kind = reqKind;
			next_addr = reqAddr;
			next_wdata = reqData;
			next_onb = onboardSel;
		end
		if (tm.tsEn) begin
			case (state)
				SBC_IDLE: begin
					// Grant only between machine cycles, so a halt is synchronous
					if (pend) begin
						next_state = SBC_T1;
					end else if (!busReq_n) begin
						next_state = SBC_GRANT;
					end
				end
				SBC_T1: begin
					next_state = SBC_T2;
				end
				SBC_T2: begin
					if (autoW != `SBC_NO_WAITS) begin
						next_state = SBC_TW;
						next_waitCnt = autoW;
					end else if (!waitRq_n) begin
						next_state = SBC_TW;
						next_waitCnt = `SBC_NO_WAITS;
					end else begin
						next_state = SBC_T3;
						next_rdData = busData;
					end
				end
				SBC_TW: begin
					// Last automatic wait also samples the wait request
					if (waitCnt > 2'h1) begin
						next_waitCnt = waitCnt - 2'h1;
					end else if (!waitRq_n) begin
						next_waitCnt = `SBC_NO_WAITS;
					end else begin
						next_state = SBC_T3;
						next_rdData = busData;
					end
				end
				SBC_T3: begin
					if (kind == SBC_FETCH) begin
						next_state = SBC_T4;
					end else begin
						next_state = SBC_IDLE;
						next_pend = 1'b0;
						next_respValid = 1'b1;
					end
				end
				SBC_T4: begin
					next_state = SBC_IDLE;
					next_pend = 1'b0;
					next_respValid = 1'b1;
					next_refCnt = {refCnt[`SBC_REF_TOP_BIT], refCnt[`SBC_REF_LOW_MSB:0] + 7'h01};
				end
				SBC_GRANT: begin
					if (busReq_n) begin
						next_state = SBC_IDLE;
					end
				end
				default: begin
					next_state = SBC_IDLE;
				end
			endcase
		end
		if (refLoad) begin
			next_refCnt = refValue;
		end
		if (!tm.sysReset_n) begin
			next_state = SBC_IDLE;
			next_pend = 1'b0;
		end
		// Holding off new work while DMA is asked lets the grant win the boundary
		next_reqReady = (next_state == SBC_IDLE) && !next_pend && busReq_n && tm.sysReset_n;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= SBC_IDLE;
			kind <= SBC_FETCH;
			addr <= 16'h0000;
			wdata <= 8'h00;
			onb <= 1'b0;
			pend <= 1'b0;
			waitCnt <= 2'h0;
			rdData <= 8'h00;
			refCnt <= 8'h00;
			respValid <= 1'b0;
			reqReady <= 1'b0;
		end else begin
			state <= next_state;
			kind <= next_kind;
			addr <= next_addr;
			wdata <= next_wdata;
			onb <= next_onb;
			pend <= next_pend;
			waitCnt <= next_waitCnt;
			rdData <= next_rdData;
			refCnt <= next_refCnt;
			respValid <= next_respValid;
			reqReady <= next_reqReady;
		end
	end

	assign respData = rdData;

	// Pin group: decoded from next state so pins line up with the state
	logic pMem;
	logic pIo;
	logic pRd;
	logic pWr;
	logic pFetch;
	logic pRef;
	logic pDrive;
	logic pGrant;
	logic [15:0] pAddr;
	logic [7:0] pData;
	logic early;
	logic mid;
	logic inCyc;

	always_comb begin
		early = (next_state == SBC_T1) || (next_state == SBC_T2) || (next_state == SBC_TW);
		mid = (next_state == SBC_T2) || (next_state == SBC_TW) || (next_state == SBC_T3);
		inCyc = early || (next_state == SBC_T3) || (next_state == SBC_T4);
		pGrant = (next_state == SBC_GRANT);
		pFetch = ((next_kind == SBC_FETCH) || (next_kind == SBC_INT_ACK)) && early;
		pMem = ((next_kind == SBC_FETCH) || (next_kind == SBC_MEM_RD) || (next_kind == SBC_MEM_WR)) && inCyc;
		pIo = (((next_kind == SBC_IO_RD) || (next_kind == SBC_IO_WR)) && mid)
			|| ((next_kind == SBC_INT_ACK) && (next_state == SBC_TW));
		pRd = ((next_kind == SBC_FETCH) && early) || ((next_kind == SBC_MEM_RD) && inCyc)
			|| ((next_kind == SBC_IO_RD) && mid);
		pWr = ((next_kind == SBC_MEM_WR) || (next_kind == SBC_IO_WR)) && mid;
		pRef = (next_kind == SBC_FETCH) && ((next_state == SBC_T3) || (next_state == SBC_T4));
		if (pRef) begin
			pAddr = {`SBC_FILL_HIGH, refCnt};
		end else if ((next_kind == SBC_IO_RD) || (next_kind == SBC_IO_WR) || (next_kind == SBC_INT_ACK)) begin
			pAddr = {`SBC_FILL_HIGH, next_addr[7:0]};
		end else begin
			pAddr = next_addr;
		end
		// Onboard memory reads (fetch, memory read) are mirrored so an analyser on the backplane sees them
		pDrive = (((next_kind == SBC_MEM_WR) || (next_kind == SBC_IO_WR)) && inCyc)
			|| (pRd && pMem && next_onb);
		pData = pDrive && pRd ? onboardData : next_wdata;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			dataOut <= 8'h00;
			dataOe_n <= 1'b1;
			addrOut <= 16'h0000;
			addrOe_n <= 1'b0;
			memReq_n <= 1'b1;
			ioReq_n <= 1'b1;
			rd_n <= 1'b1;
			wr_n <= 1'b1;
			refreshCycleFlag_n <= 1'b1;
			mcSync_n <= 1'b1;
			opcodeFetchCycleFlag_n <= 1'b1;
			intAck_n <= 1'b1;
			ctrlOe_n <= 1'b0;
			memExp_n <= 1'b0;
			ioExp_n <= 1'b0;
			busAck_n <= 1'b1;
		end else begin
			dataOut <= pData;
			dataOe_n <= !pDrive || pGrant;
			addrOut <= pAddr;
			addrOe_n <= pGrant;
			memReq_n <= !pMem;
			ioReq_n <= !pIo;
			rd_n <= !pRd;
			wr_n <= !pWr;
			refreshCycleFlag_n <= !pRef;
			mcSync_n <= !(pRd || pWr || (pFetch && pIo));
			opcodeFetchCycleFlag_n <= !pFetch;
			intAck_n <= !(pFetch && pIo);
			ctrlOe_n <= pGrant;
			memExp_n <= 1'b0;
			ioExp_n <= 1'b0;
			busAck_n <= !pGrant;
		end
	end

	assign sysReset_n = tm.sysReset_n;
	assign clockOut_n = tm.clockOut_n;
	// A plain wire through the card; no flop, so the chain adds no delay
	assign priChainOut = priChainIn;

	// Helper: wait states counted per machine cycle
	logic [1:0] twSeen;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			twSeen <= 2'h0;
		end else if (state == SBC_T1) begin
			twSeen <= 2'h0;
		end else if ((state == SBC_TW) && tm.tsEn && (twSeen != 2'h3)) begin
			twSeen <= twSeen + 2'h1;
		end
	end

	chk_onboard_mirror: assert property (@(posedge clk) disable iff (!reset_n)
		(!rd_n && !memReq_n && onb && ctrlOe_n == 1'b0) |-> !dataOe_n && dataOut == $past(onboardData))
		else $error("onboard read not driven on data bus");

	chk_data_float: assert property (@(posedge clk) disable iff (!reset_n)
		!busAck_n |-> dataOe_n)
		else $error("data driven during bus acknowledge");

	chk_addr_float: assert property (@(posedge clk) disable iff (!reset_n)
		$fell(busAck_n) |-> addrOe_n ##1 (addrOe_n || busAck_n))
		else $error("address driven during bus acknowledge");

	chk_ctrl_float: assert property (@(posedge clk) disable iff (!reset_n)
		!busAck_n |-> ctrlOe_n && !memExp_n && !ioExp_n)
		else $error("control not floated or expansion lines lost");

	chk_io_address: assert property (@(posedge clk) disable iff (!reset_n)
		(!ioReq_n && !ctrlOe_n) |-> addrOut[15:8] == `SBC_FILL_HIGH && addrOut[7:0] == addr[7:0])
		else $error("I/O port address not on low lines");

	chk_refresh_slot: assert property (@(posedge clk) disable iff (!reset_n)
		!refreshCycleFlag_n |-> kind == SBC_FETCH && (state == SBC_T3 || state == SBC_T4) && !memReq_n && rd_n)
		else $error("refresh outside T3/T4 of a fetch");

	chk_refresh_addr: assert property (@(posedge clk) disable iff (!reset_n)
		(!refreshCycleFlag_n && !$past(refLoad)) |-> addrOut[7:0] == refCnt)
		else $error("refresh address not from counter");

	chk_sync_pulse: assert property (@(posedge clk) disable iff (!reset_n)
		mcSync_n == (rd_n && wr_n && intAck_n))
		else $error("sync not formed from read, write, acknowledge");

	chk_fetch_flag: assert property (@(posedge clk) disable iff (!reset_n)
		(state == SBC_T1 && kind == SBC_FETCH) |-> !opcodeFetchCycleFlag_n && !memReq_n && !rd_n)
		else $error("opcode fetch flag missing");

	chk_ack_vector: assert property (@(posedge clk) disable iff (!reset_n)
		!intAck_n |-> !opcodeFetchCycleFlag_n && !ioReq_n && rd_n && memReq_n)
		else $error("acknowledge not fetch flag with I/O request");

	chk_grant_boundary: assert property (@(posedge clk) disable iff (!reset_n)
		$fell(busAck_n) |-> $past(state) == SBC_IDLE && !$past(busReq_n))
		else $error("bus granted inside a machine cycle");

	chk_auto_waits: assert property (@(posedge clk) disable iff (!reset_n)
		(state == SBC_T3 && $past(state) != SBC_T3) |-> twSeen >= autoW)
		else $error("automatic wait states missing");
endmodule

// *** sbc_params.svh ***
// Constants for the backplane processor interface: timing counts,
// wait-state counts and address fill values. Definitions only.
`ifndef SBC_PARAMS_SVH
`define SBC_PARAMS_SVH

`define SBC_CLK_PERIOD_NS 20
`define SBC_RESET_WIDTH_NS 2000
`define SBC_RESET_CYCLES ((`SBC_RESET_WIDTH_NS + `SBC_CLK_PERIOD_NS - 1) / `SBC_CLK_PERIOD_NS)
`define SBC_IO_WAITS 2'h1
`define SBC_INTA_WAITS 2'h2
`define SBC_NO_WAITS 2'h0
`define SBC_FILL_HIGH 8'h00
`define SBC_REF_LOW_MSB 6
`define SBC_REF_TOP_BIT 7

`endif

// *** sbc_pkg.sv ***
// Types shared by the backplane processor interface modules.
// Assumes nothing of its surroundings.
package sbc_pkg;
	typedef enum logic [2:0] {
		SBC_FETCH,
		SBC_MEM_RD,
		SBC_MEM_WR,
		SBC_IO_RD,
		SBC_IO_WR,
		SBC_INT_ACK
	} sbc_kind_e;

	typedef enum logic [2:0] {
		SBC_IDLE,
		SBC_T1,
		SBC_T2,
		SBC_TW,
		SBC_T3,
		SBC_T4,
		SBC_GRANT
	} sbc_state_e;
endpackage

// *** sbc_time_if.sv ***
// Timebase bundle: time-state enable, clock pin level, system reset level.
// Driven by the timebase, read by the bus engine.
`timescale 1ns/1ns
interface sbc_time_if;
	logic tsEn;
	logic clockOut_n;
	logic sysReset_n;
	modport src(output tsEn, clockOut_n, sysReset_n);
	modport snk(input tsEn, clockOut_n, sysReset_n);
endinterface

// *** sbc_timebase.sv ***
// Time-state clock divider and system reset one-shot.
// Assumes clk is the oscillator; the external clock pin is synchronous to clk.
`timescale 1ns/1ns
`include "sbc_params.svh"
module sbc_timebase import sbc_pkg::*; #(
	parameter int RESET_CYCLES = `SBC_RESET_CYCLES
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic pbReset_n,
	input wire logic extClk_n,
	input wire logic useExtClk,
	sbc_time_if.src tm
);
	localparam int CW = $clog2(RESET_CYCLES + 1);
	logic extPrev;
	logic next_extPrev;
	logic clkPin;
	logic next_clkPin;
	logic rstPin;
	logic next_rstPin;
	logic [CW-1:0] shot;
	logic [CW-1:0] next_shot;
	logic tick;

	always_comb begin
		// External source runs at twice the time-state rate, one tick per falling edge
		tick = useExtClk ? (extPrev && !extClk_n) : 1'b1;
		next_extPrev = extClk_n;
		next_clkPin = tick ? !clkPin : clkPin;
		next_shot = shot;
		if (!pbReset_n) begin
			next_shot = CW'(RESET_CYCLES);
		end else if (shot != '0) begin
			next_shot = shot - CW'(1);
		end
		next_rstPin = (next_shot == '0);
	end

	// Power-on loads the one-shot, so reset stays out for its full width
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			extPrev <= 1'b1;
			clkPin <= 1'b1;
			shot <= CW'(RESET_CYCLES);
			rstPin <= 1'b0;
		end else begin
			extPrev <= next_extPrev;
			clkPin <= next_clkPin;
			shot <= next_shot;
			rstPin <= next_rstPin;
		end
	end

	assign tm.tsEn = tick && clkPin;
	assign tm.clockOut_n = clkPin;
	assign tm.sysReset_n = rstPin;

	chk_clock_half_rate: assert property (@(posedge clk) disable iff (!reset_n)
		!useExtClk |=> clkPin != $past(clkPin))
		else $error("time-state clock not half the oscillator rate");

	chk_pushbutton_reset: assert property (@(posedge clk) disable iff (!reset_n)
		!pbReset_n |=> !rstPin [*2])
		else $error("pushbutton did not hold system reset");
endmodule

// *** sbc_peer_card.sv ***
// Peer card model on the backplane: port, memory and vector responder, DMA master.
// Assumes card pins settle between edges; data bus resolved here for both sides.
`timescale 1ns/1ns
module sbc_peer_card #(
	parameter logic [7:0] VECTOR = 8'he7
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [15:0] addr,
	input wire logic [7:0] cardData,
	input wire logic cardOe_n,
	input wire logic memReq_n,
	input wire logic ioReq_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic intAck_n,
	input wire logic dmaReq,
	input wire logic slow,
	output logic [7:0] busData,
	output logic [7:0] lastWrite,
	output logic busReq_n,
	output logic waitRq_n
);
	logic [7:0] filler;
	logic [2:0] waitCnt;
	logic prevIdle;

	// Released bus shows a changing pattern, never a stale byte
	always_comb begin
		if (!cardOe_n) begin
			busData = cardData;
		end else if (!intAck_n) begin
			busData = VECTOR;
		end else if (!ioReq_n && !rd_n) begin
			busData = addr[7:0] ^ 8'h5a;
		end else if (!memReq_n && !rd_n && addr[15]) begin
			busData = addr[7:0] + addr[15:8];
		end else begin
			busData = filler;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			filler <= 8'h00;
			waitCnt <= 3'h0;
			prevIdle <= 1'b1;
			busReq_n <= 1'b1;
			lastWrite <= 8'h00;
		end else begin
			filler <= ~busData;
			prevIdle <= memReq_n & ioReq_n;
			if (slow && prevIdle && !(memReq_n & ioReq_n)) begin
				waitCnt <= 3'h6;
			end else if (waitCnt != 3'h0) begin
				waitCnt <= waitCnt - 3'h1;
			end
			busReq_n <= !dmaReq;
			if (!wr_n && !cardOe_n) begin
				lastWrite <= cardData;
			end
		end
	end

	// Slow responder holds off the cycle across the sample point
	assign waitRq_n = (waitCnt == 3'h0);
endmodule

// *** tb_top.sv ***
// Self-checking bench: processor-side requests against a bench model and a peer card.
// Assumes the time base runs from clk; the last round clocks from the external pin.
`timescale 1ns/1ns
module tb_top import sbc_pkg::*; ;
	localparam int RC = 4;
	localparam logic [7:0] VEC = 8'he7;
	logic clk, reset_n, reqValid, onboardSel, refLoad, pbReset_n, priChainIn, dmaReq, slow;
	logic useExtClk, extClk_n, extPh;
	sbc_kind_e reqKind;
	logic [15:0] reqAddr, addrOut, addrSeen, refAddr;
	logic [7:0] reqData, onboardData, refValue, dataIn, dataOut, respData, lastWrite;
	logic reqReady, respValid, dataOe_n, addrOe_n, memReq_n, ioReq_n, rd_n, wr_n, refreshCycleFlag_n;
	logic mcSync_n, opcodeFetchCycleFlag_n, intAck_n, ctrlOe_n, memExp_n, ioExp_n, busReq_n, busAck_n;
	logic waitRq_n, sysReset_n, clockOut_n, priChainOut, prevMc, prevFetch, intaSeen, oeSeen, refTop;
	logic [6:0] refCnt;
	int errCount, testsRun, mcCnt, fetchCnt, rfshCnt;
	integer seed;

	sbc_std_bus_interface #(.RESET_CYCLES(RC)) sbc_std_bus_interface_inst (
		.clk(clk), .reset_n(reset_n), .reqValid(reqValid), .reqKind(reqKind), .reqAddr(reqAddr),
		.reqData(reqData), .reqReady(reqReady), .respValid(respValid), .respData(respData),
		.onboardSel(onboardSel), .onboardData(onboardData), .refLoad(refLoad), .refValue(refValue),
		.useExtClk(useExtClk), .extClk_n(extClk_n), .pbReset_n(pbReset_n), .dataIn(dataIn), .dataOut(dataOut),
		.dataOe_n(dataOe_n), .addrOut(addrOut), .addrOe_n(addrOe_n), .memReq_n(memReq_n), .ioReq_n(ioReq_n),
		.rd_n(rd_n), .wr_n(wr_n), .refreshCycleFlag_n(refreshCycleFlag_n), .mcSync_n(mcSync_n),
		.opcodeFetchCycleFlag_n(opcodeFetchCycleFlag_n), .intAck_n(intAck_n), .ctrlOe_n(ctrlOe_n),
		.memExp_n(memExp_n), .ioExp_n(ioExp_n), .busReq_n(busReq_n), .busAck_n(busAck_n),
		.waitRq_n(waitRq_n), .sysReset_n(sysReset_n), .clockOut_n(clockOut_n),
		.priChainIn(priChainIn), .priChainOut(priChainOut));

	sbc_peer_card #(.VECTOR(VEC)) sbc_peer_card_inst (
		.clk(clk), .reset_n(reset_n), .addr(addrOut), .cardData(dataOut), .cardOe_n(dataOe_n),
		.memReq_n(memReq_n), .ioReq_n(ioReq_n), .rd_n(rd_n), .wr_n(wr_n), .intAck_n(intAck_n),
		.dmaReq(dmaReq), .slow(slow), .busData(dataIn), .lastWrite(lastWrite), .busReq_n(busReq_n),
		.waitRq_n(waitRq_n));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// External source: pin period of four clk, so one time state lasts eight clk
	always @(posedge clk) begin
		if (!reset_n) begin
			extPh <= 1'b0;
			extClk_n <= 1'b1;
		end else begin
			extPh <= !extPh;
			if (useExtClk && extPh) extClk_n <= !extClk_n;
		end
	end

	// Pin monitor at the falling edge, clear of launch edges
	always @(negedge clk) begin
		if (!mcSync_n && prevMc) mcCnt++;
		if (!opcodeFetchCycleFlag_n && prevFetch) fetchCnt++;
		if (!refreshCycleFlag_n) begin
			rfshCnt++;
			refAddr = addrOut;
		end
		if ((!memReq_n || !ioReq_n) && refreshCycleFlag_n) addrSeen = addrOut;
		if (!intAck_n) intaSeen = 1'b1;
		if (!dataOe_n) oeSeen = 1'b1;
		prevMc = mcSync_n;
		prevFetch = opcodeFetchCycleFlag_n;
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		testsRun++;
		if (seen !== exp) begin
			errCount++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic testDone();
		$display("Counts: %0d compared, %0d mismatched", testsRun, errCount);
		if (errCount == 0 && testsRun > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic waitHigh(ref logic sig, input logic lvl, input int bound, output int n);
		n = 0;
		while (sig !== lvl && n < bound) begin
			@(posedge clk);
			n++;
		end
		if (n >= bound) begin
			check("timeout", 0, 1);
			testDone();
		end
	endtask

	task automatic doCycle(input sbc_kind_e kind, input logic [15:0] addr, input logic slowOn, input int tsClk);
		int lat, tLen;
		logic [7:0] wdat, expData;
		logic onb, isWr;
		wdat = $random(seed);
		onb = !addr[15] && (kind == SBC_FETCH || kind == SBC_MEM_RD);
		isWr = (kind == SBC_MEM_WR || kind == SBC_IO_WR);
		tLen = (kind == SBC_INT_ACK) ? 5 : (kind == SBC_MEM_RD || kind == SBC_MEM_WR) ? 3 : 4;
		expData = onb ? addr[7:0] ^ 8'h3c : (kind == SBC_IO_RD) ? addr[7:0] ^ 8'h5a : addr[7:0] + addr[15:8];
		if (kind == SBC_INT_ACK) expData = VEC;
		slow <= slowOn;
		onboardData <= addr[7:0] ^ 8'h3c;
		reqValid <= 1'b1;
		reqKind <= kind;
		reqAddr <= addr;
		reqData <= wdat;
		onboardSel <= onb;
		lat = 0;
		do begin
			@(posedge clk);
			lat++;
		end while (!(reqReady === 1'b1) && lat < 300);
		if (reqReady !== 1'b1) begin
			check("readyTimeout", 0, 1);
			testDone();
		end
		reqValid <= 1'b0;
		{mcCnt, fetchCnt, rfshCnt, intaSeen, oeSeen} = '0;
		addrSeen = 16'h0000;
		lat = 0;
		do begin
			@(posedge clk);
			lat++;
		end while (!(respValid === 1'b1) && lat < 300);
		if (respValid !== 1'b1) begin
			check("respTimeout", 0, 1);
			testDone();
		end
		if (!isWr) check("respData", respData, expData);
		check("syncPulses", mcCnt, 1);
		check("fetchPulses", fetchCnt, kind == SBC_FETCH || kind == SBC_INT_ACK);
		check("refreshClks", rfshCnt, (kind == SBC_FETCH) ? 2 * tsClk : 0);
		if (kind == SBC_FETCH) begin
			check("refreshAddr", refAddr, {8'h00, refTop, refCnt});
			refCnt++;
		end
		if (kind != SBC_INT_ACK) begin
			check("address", addrSeen, (kind == SBC_IO_RD || kind == SBC_IO_WR) ? {8'h00, addr[7:0]} : addr);
		end
		check("intAck", intaSeen, kind == SBC_INT_ACK);
		check("dataDirection", oeSeen, isWr || onb);
		if (isWr) check("writeData", lastWrite, wdat);
		// Up to one time state to reach the first boundary, plus one clk to see the pulse
		check("latency", lat >= tsClk * tLen + (slowOn ? 4 : 2) && lat <= tsClk * tLen + tsClk + 1 + (slowOn ? 10 : 0), 1);
		if (slowOn) check("waitStretch", lat >= tsClk * tLen + tsClk + 2, 1);
	endtask

	task automatic dmaTest();
		int n, togg;
		logic prevClk;
		dmaReq <= 1'b1;
		waitHigh(busAck_n, 1'b0, 60, n);
		@(negedge clk);
		check("busAck", busAck_n, 0);
		check("dataFloat", dataOe_n, 1);
		check("addrFloat", addrOe_n, 1);
		check("ctrlFloat", ctrlOe_n, 1);
		check("expansion", {memExp_n, ioExp_n}, 0);
		@(posedge clk);
		reqValid <= 1'b1;
		togg = 0;
		@(negedge clk);
		prevClk = clockOut_n;
		for (n = 0; n < 20; n++) begin
			@(posedge clk);
			priChainIn <= n[0];
			@(negedge clk);
			check("priChain", priChainOut, n[0]);
			check("refusedInGrant", reqReady, 0);
			if (clockOut_n !== prevClk) togg++;
			prevClk = clockOut_n;
		end
		check("clockToggles", togg, 20);
		@(posedge clk);
		reqValid <= 1'b0;
		dmaReq <= 1'b0;
		waitHigh(busAck_n, 1'b1, 60, n);
	endtask

	task automatic sysResetTest();
		int n;
		waitHigh(sysReset_n, 1'b1, 60, n);
		check("resetWidth", n >= RC && n <= RC + 3, 1);
	endtask

	initial begin
		seed = 32'h796e;
		{errCount, testsRun, mcCnt, fetchCnt, rfshCnt} = '0;
		{reset_n, reqValid, onboardSel, refLoad, dmaReq, slow, priChainIn, useExtClk} = '0;
		{prevMc, prevFetch, pbReset_n} = 3'h7;
		reqKind = SBC_FETCH;
		{reqAddr, reqData, onboardData, refValue} = '0;
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		sysResetTest();
		@(posedge clk);
		refValue <= $random(seed);
		refLoad <= 1'b1;
		@(posedge clk);
		refLoad <= 1'b0;
		{refTop, refCnt} = refValue;
		for (int r = 0; r < 3; r++) begin
			if (r == 1) begin
				dmaTest();
				$display("Test bus grant done");
			end
			if (r == 2) useExtClk <= 1'b1;
			for (int k = 0; k < 6; k++) begin
				doCycle(sbc_kind_e'(k), $random(seed), r == 1, (r == 2) ? 8 : 2);
			end
			$display("Test cycle round %0d done", r);
		end
		pbReset_n <= 1'b0;
		repeat (3) @(posedge clk);
		check("pushbutton", sysReset_n, 0);
		pbReset_n <= 1'b1;
		sysResetTest();
		$display("Test pushbutton reset done");
		testDone();
	end
endmodule
